// *** hw/psbs_burst_addr.sv ***
// burst address sequencer: linear or interleaved order on the low address bits
`timescale 1ns/1ps
module psbs_burst_addr #(
  parameter int ADDR_W  = 20,
  parameter int BURST_W = 2
) (
  input  wire logic [ADDR_W-1:0]  base,
  input  wire logic [BURST_W-1:0] count,
  input  wire logic               interleaved,
  output logic      [ADDR_W-1:0]  next_addr
);

  logic [BURST_W-1:0] linear_low;
  logic [BURST_W-1:0] xor_low;
  logic [BURST_W-1:0] sel_low;

  assign linear_low = base[BURST_W-1:0] + count;
  assign xor_low    = base[BURST_W-1:0] ^ count;
  assign sel_low    = interleaved ? xor_low : linear_low;
  assign next_addr  = {base[ADDR_W-1:BURST_W], sel_low};

endmodule // psbs_burst_addr

// *** hw/psbs_defines.svh ***
// constants for the pipelined synchronous burst memory
`ifndef PSBS_DEFINES_SVH
`define PSBS_DEFINES_SVH

`define PSBS_ADDR_W   20
`define PSBS_DATA_W   36
`define PSBS_LANE_W   9
`define PSBS_BURST_W  2
`define PSBS_READ_LAT 1

`endif

// *** hw/psbs_pkg.sv ***
// types shared by the burst memory design
package psbs_pkg;

  typedef enum logic [1:0] {
    PSBS_OP_NOP   = 2'b00,
    PSBS_OP_READ  = 2'b01,
    PSBS_OP_WRITE = 2'b10
  } psbs_op_e;

endpackage

// *** hw/psbs_top.sv ***
// pipelined synchronous burst static memory, device side
// Functional notes
// [RULE_01] All synchronous inputs are captured in input registers on the rising edge; dq_in has none and goes straight to the array and the read bypass.
// [RULE_02] Read data leaves through an output register updated on the rising edge.
// [RULE_03] Clock qualify deasserted ignores the edge and holds every internal state; sleep_active still follows sleep_request on such edges.
// [RULE_04] A write updates only lanes whose byte-write select is active with write strobe.
// [RULE_05] Writes complete internally; no external write pulse width is needed.
// [RULE_06] Selected only when first and third selects low and second high.
// [RULE_07] Data drivers are synchronously off during the data phase of any write.
// [RULE_08] Reads and writes may follow in any order on consecutive cycles.
// [RULE_09] Bursts step in linear or interleaved order chosen by a static input.
// [RULE_10] Sleep input stops new accesses and drivers; state kept, clock may stop.
// [RULE_11] Output driver enabling is timed internally, not by toggling output enable.
// [RULE_12] Array is 1M x 36, 2M x 18 or 512K x 72 by parameters.
// [RULE_13] Address at edge n: read data sampled at n+2, write data sampled at n+2.
// [RULE_14] Advance high continues the burst; low loads a new address and operation.
`timescale 1ns/1ps
`include "psbs_defines.svh"
module psbs_top #(
  parameter int ADDR_W  = `PSBS_ADDR_W,
  parameter int DATA_W  = `PSBS_DATA_W,
  parameter int LANE_W  = `PSBS_LANE_W,
  parameter int BURST_W = `PSBS_BURST_W
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [ADDR_W-1:0]          addr,
  input  wire logic                       write_n,
  input  wire logic [DATA_W/LANE_W-1:0]   byte_lane_write_n,
  input  wire logic                       chip_select_first_n,
  input  wire logic                       chip_select_second,
  input  wire logic                       chip_select_third_n,
  input  wire logic                       advance_or_load,
  input  wire logic                       clock_qualify_n,
  input  wire logic                       output_enable_n,
  input  wire logic                       sleep_request,
  input  wire logic                       burst_interleaved,
  input  wire logic [DATA_W-1:0]          dq_in,
  output logic      [DATA_W-1:0]          dq_out,
  output logic                            dq_oe,
  output logic                            sleep_active
);
  import psbs_pkg::*;

  localparam int LANES = DATA_W / LANE_W;
  localparam int DEPTH = 1 << ADDR_W; // [RULE_12]

  logic [DATA_W-1:0] mem [0:DEPTH-1];

  // load stage (address registered at edge n)
  psbs_op_e             a_op;
  logic [ADDR_W-1:0]    a_addr;
  logic [ADDR_W-1:0]    a_base;
  logic [BURST_W-1:0]   a_cnt;
  logic [LANES-1:0]     a_be;
  // data stage (one edge later)
  psbs_op_e             b_op;
  logic [ADDR_W-1:0]    b_addr;
  logic [LANES-1:0]     b_be;

  logic                 qualify;
  logic                 selected;
  logic                 load_new;
  psbs_op_e             next_a_op;
  logic [ADDR_W-1:0]    next_a_addr;
  logic [ADDR_W-1:0]    next_a_base;
  logic [BURST_W-1:0]   next_a_cnt;
  logic [BURST_W-1:0]   cnt_step;
  logic [ADDR_W-1:0]    burst_addr;
  logic [DATA_W-1:0]    rd_word;
  logic [DATA_W-1:0]    fwd_word;
  logic                 b_is_write;
  logic                 fwd_hit;
  logic                 next_dq_oe;

  assign qualify    = !clock_qualify_n; // [RULE_03]
  assign selected   = !chip_select_first_n && chip_select_second
                      && !chip_select_third_n; // [RULE_06]
  assign load_new   = !advance_or_load; // [RULE_14]
  assign cnt_step   = a_cnt + {{(BURST_W-1){1'b0}}, 1'b1};

  psbs_burst_addr #(
    .ADDR_W  (ADDR_W),
    .BURST_W (BURST_W)
  ) u_burst (
    .base        (a_base),
    .count       (cnt_step),
    .interleaved (burst_interleaved),
    .next_addr   (burst_addr)
  ); // [RULE_09]

  // a new access is loaded or the running burst steps on; sleep turns loads and burst steps into no-ops
  assign next_a_op   = sleep_request ? PSBS_OP_NOP :
                       load_new ? (!selected ? PSBS_OP_NOP :
                                   (write_n ? PSBS_OP_READ : PSBS_OP_WRITE)) :
                       a_op; // [RULE_14] [RULE_10] [RULE_06]
  assign next_a_addr = load_new ? addr : burst_addr; // [RULE_14]
  assign next_a_base = load_new ? addr : a_base;
  assign next_a_cnt  = load_new ? {BURST_W{1'b0}} : cnt_step;

  // load stage input registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_op   <= PSBS_OP_NOP;
      a_addr <= '0;
      a_base <= '0;
      a_cnt  <= '0;
      a_be   <= '0;
    end else if (qualify) begin // [RULE_03]
      a_op   <= next_a_op; // [RULE_01]
      a_addr <= next_a_addr;
      a_base <= next_a_base;
      a_cnt  <= next_a_cnt;
      a_be   <= ~byte_lane_write_n; // [RULE_04]
    end
  end

  // data stage follows the load stage every qualified edge, no bubbles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      b_op   <= PSBS_OP_NOP;
      b_addr <= '0;
      b_be   <= '0;
    end else if (qualify) begin
      b_op   <= a_op; // [RULE_08]
      b_addr <= a_addr;
      b_be   <= a_be;
    end
  end

  assign b_is_write = (b_op == PSBS_OP_WRITE);
  assign fwd_hit    = b_is_write && (b_addr == a_addr);
  assign rd_word    = mem[a_addr];

  // write data is taken straight into the array at edge n+2, lane by lane;
  // one process owns the array so every lane shares a single driver
  always_ff @(posedge clk) begin
    if (qualify && b_is_write) begin // [RULE_05] [RULE_13]
      for (int i = 0; i < LANES; i++) begin
        if (b_be[i]) begin // [RULE_04]
          mem[b_addr][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // a read one cycle behind the write sees the same lanes through the bypass
  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      assign fwd_word[l*LANE_W +: LANE_W] = (fwd_hit && b_be[l]) ?
                                            dq_in[l*LANE_W +: LANE_W] :
                                            rd_word[l*LANE_W +: LANE_W]; // [RULE_08]
    end
  endgenerate

  // drivers come on only for a read in the data phase; output enable just gates it
  assign next_dq_oe = (a_op == PSBS_OP_READ) && !output_enable_n
                      && !sleep_request; // [RULE_11] [RULE_07] [RULE_10]

  // output registers: read data loaded at edge n+1, held across edge n+2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end else if (qualify) begin // [RULE_03]
      dq_oe <= next_dq_oe; // [RULE_07] [RULE_11]
      if (a_op == PSBS_OP_READ) begin
        dq_out <= fwd_word; // [RULE_02] [RULE_13]
      end
    end
  end

  // sleep status follows the request even while the clock is not qualified
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_active <= 1'b0;
    end else begin
      sleep_active <= sleep_request; // [RULE_10]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_rd_issue;
    !clock_qualify_n && !advance_or_load && selected && write_n && !sleep_request;
  endsequence

  sequence seq_wr_issue;
    !clock_qualify_n && !advance_or_load && selected && !write_n && !sleep_request;
  endsequence

  sequence seq_rd_data_phase;
    !clock_qualify_n && !output_enable_n && !sleep_request;
  endsequence

  AST_STALL_HOLDS_OUTPUTS: assert property ( // [RULE_03]
    clock_qualify_n |=> $stable(dq_out) && $stable(dq_oe) && $stable(a_addr))
    else $error("outputs or state changed on an unqualified edge");

  AST_STALL_HOLDS_PIPE: assert property ( // [RULE_03]
    clock_qualify_n |=> (b_op == $past(b_op)) && (a_op == $past(a_op)))
    else $error("pipeline moved on an unqualified edge");

  AST_READ_LATENCY: assert property ( // [RULE_13]
    seq_rd_issue ##1 seq_rd_data_phase |=> dq_oe)
    else $error("read data not driven one edge after its address");

  AST_READ_DRIVES: assert property ( // [RULE_02]
    seq_rd_issue ##1 (!clock_qualify_n && !fwd_hit) |=> dq_out == $past(rd_word))
    else $error("read data does not match the array word");

  AST_WRITE_TRISTATE: assert property ( // [RULE_07]
    seq_wr_issue ##1 !clock_qualify_n |=> !dq_oe)
    else $error("drivers on during a write data phase");

  AST_DESELECT_NOP: assert property ( // [RULE_06]
    (!clock_qualify_n && !advance_or_load && !selected) |=> a_op == PSBS_OP_NOP)
    else $error("access loaded without all chip selects active");

  AST_LOAD_ADDR: assert property ( // [RULE_01]
    (!clock_qualify_n && !advance_or_load) |=> a_addr == $past(addr) && a_cnt == '0)
    else $error("load did not register the address");

  AST_BURST_STEP: assert property ( // [RULE_14]
    (!clock_qualify_n && advance_or_load && !sleep_request)
      |=> a_cnt == $past(cnt_step) && a_op == $past(a_op)
          && a_addr[ADDR_W-1:BURST_W] == $past(a_base[ADDR_W-1:BURST_W]))
    else $error("burst advance did not continue the access");

  AST_BURST_ORDER: assert property ( // [RULE_09]
    (!clock_qualify_n && advance_or_load && burst_interleaved)
      |=> a_addr[BURST_W-1:0] == ($past(a_base[BURST_W-1:0]) ^ $past(cnt_step)))
    else $error("interleaved burst order broken");

  AST_BACK_TO_BACK: assert property ( // [RULE_08]
    seq_wr_issue ##1 seq_rd_issue ##1 seq_rd_data_phase |=> dq_oe)
    else $error("read right after a write was delayed");

  AST_LANE_BYPASS: assert property ( // [RULE_04]
    (!clock_qualify_n && fwd_hit && b_be[0] && a_op == PSBS_OP_READ)
      |=> dq_out[LANE_W-1:0] == $past(dq_in[LANE_W-1:0]))
    else $error("written lane not seen by the following read");

  AST_LANE_MASKED: assert property ( // [RULE_04]
    (!clock_qualify_n && fwd_hit && !b_be[0] && a_op == PSBS_OP_READ)
      |=> dq_out[LANE_W-1:0] == $past(rd_word[LANE_W-1:0]))
    else $error("masked lane was overwritten");

  AST_SLEEP_QUIET: assert property ( // [RULE_10]
    (sleep_request && !clock_qualify_n) |=> !dq_oe ##1 (!clock_qualify_n -> !dq_oe))
    else $error("drivers on while sleep is requested");

endmodule // psbs_top

// *** sim/psbs_ctrl_model.sv ***
// controller-side bus model: loads, bursts, stalls and write data two qualified cycles later
`timescale 1ns/1ps
module psbs_ctrl_model (
  input  wire logic        clk,
  input  wire logic [35:0] dq_out,
  input  wire logic        dq_oe,
  output logic      [7:0]  addr,
  output logic             write_n,
  output logic      [3:0]  byte_lane_write_n,
  output logic             chip_select_first_n,
  output logic             chip_select_second,
  output logic             chip_select_third_n,
  output logic             advance_or_load,
  output logic             clock_qualify_n,
  output logic             output_enable_n,
  output logic             sleep_request,
  output logic             burst_interleaved,
  output logic      [35:0] dq_in
);
  logic [35:0] p0, p1, rq;
  logic        v0, v1, lw, roe;
  initial begin
    {addr, write_n, byte_lane_write_n, advance_or_load} = '1;
    {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'b010;
    {clock_qualify_n, output_enable_n, sleep_request, burst_interleaved} = '0;
    {dq_in, p0, p1} = '0;
    {v0, v1, lw} = '0;
  end
  // one qualified cycle; captures outputs after its edge
  task automatic cyc(input logic wn, adv, input logic [7:0] a, input logic [3:0] ln,
                     input logic [35:0] d);
    dq_in = v1 ? p1 : ~dq_in;
    {p1, v1} = {p0, v0};
    lw = adv ? lw : !wn;
    {p0, v0} = {d, lw};
    {addr, write_n, advance_or_load, clock_qualify_n} = {a, wn, adv, 1'b0};
    byte_lane_write_n = ln;
    @(negedge clk);
    // a bus left undriven is not seen as the last word
    {rq, roe} = {dq_oe ? dq_out : ~dq_out, dq_oe};
  endtask
  // controller holds the pipeline for one edge
  task automatic stall();
    clock_qualify_n = 1'b1;
    @(negedge clk);
    {rq, roe} = {dq_oe ? dq_out : ~dq_out, dq_oe};
  endtask
endmodule // psbs_ctrl_model

// *** sim/test_pipelined_sync_burst_sram.sv ***
// self-checking bench: pipelined reads, lane writes, bursts, stalls, selects, sleep
`timescale 1ns/1ps
module test_pipelined_sync_burst_sram;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr;
  logic [3:0]  byte_lane_write_n;
  logic [35:0] dq_in, dq_out, pe, sh [256];
  logic        write_n, chip_select_first_n, chip_select_second, chip_select_third_n;
  logic        advance_or_load, clock_qualify_n, output_enable_n, sleep_request;
  logic        burst_interleaved, dq_oe, sleep_active;
  logic        pv = 1'b0;
  int          fails = 0;
  int          compares = 0;

  psbs_top #(
    .ADDR_W (8)
  ) dut_u (
    .clk                 (clk),
    .rst_n               (rst_n),
    .addr                (addr),
    .write_n             (write_n),
    .byte_lane_write_n   (byte_lane_write_n),
    .chip_select_first_n (chip_select_first_n),
    .chip_select_second  (chip_select_second),
    .chip_select_third_n (chip_select_third_n),
    .advance_or_load     (advance_or_load),
    .clock_qualify_n     (clock_qualify_n),
    .output_enable_n     (output_enable_n),
    .sleep_request       (sleep_request),
    .burst_interleaved   (burst_interleaved),
    .dq_in               (dq_in),
    .dq_out              (dq_out),
    .dq_oe               (dq_oe),
    .sleep_active        (sleep_active)
  );
  psbs_ctrl_model m (
    .clk                 (clk),
    .dq_out              (dq_out),
    .dq_oe               (dq_oe),
    .addr                (addr),
    .write_n             (write_n),
    .byte_lane_write_n   (byte_lane_write_n),
    .chip_select_first_n (chip_select_first_n),
    .chip_select_second  (chip_select_second),
    .chip_select_third_n (chip_select_third_n),
    .advance_or_load     (advance_or_load),
    .clock_qualify_n     (clock_qualify_n),
    .output_enable_n     (output_enable_n),
    .sleep_request       (sleep_request),
    .burst_interleaved   (burst_interleaved),
    .dq_in               (dq_in)
  );

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [35:0] got, exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one load or advance; judges the read taken one qualified edge earlier
  task automatic step(input logic wn, adv, live, input logic [7:0] a,
                      input logic [3:0] ln = 4'h0, input logic [35:0] d = '0);
    m.cyc(wn, adv, a, ln, d);
    chk(m.roe, pv & !output_enable_n);
    if (pv && !output_enable_n) chk(m.rq, pe);
    pv = live & wn;
    pe = sh[a];
    if (live && !wn) for (int i = 0; i < 4; i++) if (!ln[i]) sh[a][9*i +: 9] = d[9*i +: 9];
  endtask

  // deselected cycles; the select is raised once for the whole run of them
  task automatic idle(input int n);
    m.chip_select_first_n = 1'b1;
    repeat (n) step(1, 0, 0, 8'h00);
    m.chip_select_first_n = 1'b0;
  endtask

  task automatic t_mix();
    step(0, 0, 1, 8'h10, 4'h0, 36'h123456789);
    step(0, 0, 1, 8'h11, 4'h0, 36'hfedcba987);
    step(0, 0, 1, 8'h11, 4'ha, 36'h0aaaa5555);
    step(1, 0, 1, 8'h11);
    step(0, 0, 1, 8'h10, 4'h6, 36'h5a5a5a5a5);
    step(1, 0, 1, 8'h10);
    step(1, 0, 1, 8'h10);
    m.output_enable_n = 1'b1;
    step(1, 0, 1, 8'h10);
    step(1, 0, 1, 8'h11);
    m.output_enable_n = 1'b0;
    step(0, 0, 1, 8'h11, 4'h1, 36'h3c3c3c3c3);
    step(1, 0, 1, 8'h11);
    idle(2);
  endtask

  task automatic t_desel();
    logic [2:0] bad [3] = '{3'b110, 3'b000, 3'b011};
    foreach (bad[i]) begin
      {m.chip_select_first_n, m.chip_select_second, m.chip_select_third_n} = bad[i];
      step(0, 0, 0, 8'h10, 4'h0, 36'h0);
      step(1, 0, 0, 8'h10);
    end
    {m.chip_select_second, m.chip_select_third_n} = 2'b10;
    idle(1);
    step(1, 0, 1, 8'h10);
    idle(1);
  endtask

  task automatic t_stall();
    step(0, 0, 1, 8'h12, 4'h0, 36'h0c3c3c3c3);
    m.stall();
    m.stall();
    step(1, 0, 1, 8'h12);
    m.stall();
    idle(2);
  endtask

  task automatic t_burst();
    logic [7:0] a;
    for (int il = 0; il < 2; il++) begin
      m.burst_interleaved = il[0];
      for (int k = 0; k < 8; k++) begin
        a = {6'h05, il[0] ? 2'(1 ^ k) : 2'(1 + k)};
        step(k >= 4, k % 4 != 0, 1, a, 4'h0, 36'(il * 16 + k));
      end
      idle(1);
    end
  endtask

  task automatic t_sleep();
    m.sleep_request = 1'b1;
    step(0, 0, 0, 8'h10, 4'h0, 36'h0);
    step(1, 0, 0, 8'h10);
    chk(sleep_active, 1'b1);
    m.sleep_request = 1'b0;
    idle(1);
    chk(sleep_active, 1'b0);
    step(1, 0, 1, 8'h10);
    idle(1);
  endtask

  task automatic final_report();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_mix();
    t_desel();
    t_stall();
    t_burst();
    t_sleep();
    final_report();
  end

  initial begin
    #100000;
    fails++;
    final_report();
  end
endmodule // test_pipelined_sync_burst_sram
